// >>> dsio_regs.svh
// Constants for the direct-store transaction block.
`ifndef DSIO_REGS_SVH
`define DSIO_REGS_SVH
`define DSIO_XC_LOAD_REQ   8'h40
`define DSIO_XC_LOAD_IMM   8'h50
`define DSIO_XC_LOAD_LAST  8'h70
`define DSIO_XC_STORE_IMM  8'h10
`define DSIO_XC_STORE_LAST 8'h30
`define DSIO_XC_LOAD_RPLY  8'hc0
`define DSIO_XC_STORE_RPLY 8'h80
`define DSIO_MAX_BYTES     8'h80
`define DSIO_BEAT_BYTES    3'h4
`define DSIO_ZERO2         2'h0
`define DSIO_ZERO8         8'h00
`define DSIO_ZERO32        32'h0000_0000
`define DSIO_DW_MASK       3'h7
`define DSIO_DW_BYTES      4'h8
`define DSIO_ONE8          8'h01
`define DSIO_ONE3          3'h1
`endif

// >>> dsio_pkg.sv
// Types shared by the direct-store transaction block.
package dsio_pkg;
  typedef struct packed {
    logic        is_load;
    logic        user_mode;
    logic [31:0] ea;
    logic [7:0]  byte_count;
    logic [31:0] seg;
  } dsio_req_t;
  typedef struct packed {
    logic        done;
    logic        error;
    logic        mcheck;
  } dsio_done_t;
  typedef enum logic [2:0] {
    DSIO_IDLE = 3'b000,
    DSIO_REQ0 = 3'b001,
    DSIO_REQ1 = 3'b011,
    DSIO_DATA = 3'b010,
    DSIO_WAIT = 3'b110,
    DSIO_RPLY = 3'b111
  } dsio_state_t;
endpackage

// >>> dsio_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module dsio_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s1_reg <= '0;
      q_out  <= '0;
    end
    else
    begin
      s1_reg <= d_in;
      q_out  <= s1_reg;
    end
  end
endmodule
`default_nettype wire

// >>> dsio_core.sv
// Direct-store transaction logic: packet forming, beats and reply decode.
// Contract
// - First beat drives address lines 0 and 1 low.
// - First-beat line 2 carries user or supervisor key by processor state.
// - First-beat lines 3-27 copy segment bits 3-27; 3-11 is the unit tag.
// - First-beat lines 28-31 carry the processor tag.
// - Load request second beat code carries total byte count, at most 128.
// - Immediate and last second beat code carries beat byte count 1-4.
// - Second beat address is segment bits 28-31 over EA bits 4-31.
// - Reply line 2 is error, 3-11 unit tag, 12-27 ignored.
// - Accept reply only when lines 28-31 equal the processor tag.
// - Error reply completes instruction then raises direct-store error; here done_out.error pulses one cycle before done_out.done.
// - Replies while nothing waits are ignored.
// - Check address parity on operations and replies when enabled.
// - No immediate op for at most 4 bytes not crossing 8 bytes.
// - First beat valid one cycle with strobe; acknowledge may hold second.
// - No new direct-store access once one has started its tenure.
// - Data uses upper 32 lanes only; no request before store data.
// - Transfer error defers, finishes data, ignores reply, then machine check.
// - Transfer code is type, burst, size; opcodes fixed.
// - Wait for reply before starting a new access.
`include "dsio_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dsio_core (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire dsio_pkg::dsio_req_t req_in,
  input  wire logic              req_valid_in,
  input  wire logic [31:0]       store_data_in,
  input  wire logic [3:0]        processor_tag_in,
  input  wire logic              parity_enable_in,
  input  wire logic              addr_acknowledge_in,
  input  wire logic              transfer_error_ack_in,
  input  wire logic              data_ack_in,
  input  wire logic [31:0]       addr_in,
  input  wire logic [7:0]        ext_transfer_code_in,
  input  wire logic              ext_addr_start_strobe_in,
  input  wire logic [3:0]        addr_parity_in,
  input  wire logic [31:0]       upper_data_lanes_in,
  output var  logic              req_ready_out,
  output var  logic [31:0]       addr_out,
  output var  logic [7:0]        ext_transfer_code_out,
  output var  logic              ext_addr_start_strobe_out,
  output var  logic              addr_oe_n_out,
  output var  logic [31:0]       upper_data_lanes_out,
  output var  logic              data_oe_n_out,
  output var  logic [31:0]       load_data_out,
  output var  logic              load_data_valid_out,
  output var  dsio_pkg::dsio_done_t done_out,
  output var  logic              parity_error_out
);
  logic [31:0]         addr_s;
  logic [7:0]          code_s;
  logic                strobe_s;
  logic [3:0]          par_s;
  logic                addr_acknowledge_s;
  logic                tea_s;
  logic                ta_s;
  logic [31:0]         dh_s;
  dsio_pkg::dsio_state_t state_reg;
  dsio_pkg::dsio_req_t   req_reg;
  logic [7:0]          left_reg;
  logic [31:0]         ptr_reg;
  logic                load_sent_reg;
  logic                tea_seen_reg;
  logic [2:0]          beat_bytes;
  logic                last_beat;

  dsio_sync #(.W(80)) u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .d_in      ({addr_in, ext_transfer_code_in, ext_addr_start_strobe_in, addr_parity_in,
                 addr_acknowledge_in, transfer_error_ack_in, data_ack_in, upper_data_lanes_in}),
    .q_out     ({addr_s, code_s, strobe_s, par_s, addr_acknowledge_s, tea_s, ta_s, dh_s})
  );

  // Bytes that fit before the next double-word boundary, at most one lane word, capped by what is left.
  // Splitting at double words rather than words keeps short accesses to a single last operation.
  function automatic logic [2:0] beat_len(input logic [31:0] a, input logic [7:0] n);
    logic [3:0] room;
    logic [2:0] cap;
    room = `DSIO_DW_BYTES - {1'b0, a[2:0]};
    cap = (room > {1'b0, `DSIO_BEAT_BYTES}) ? `DSIO_BEAT_BYTES : room[2:0];
    beat_len = (n < {5'h00, cap}) ? n[2:0] : cap;
  endfunction

  function automatic logic par_ok(input logic [31:0] a, input logic [3:0] p);
    par_ok = (^a[31:24] ^ p[3]) & (^a[23:16] ^ p[2]) & (^a[15:8] ^ p[1]) & (^a[7:0] ^ p[0]);
  endfunction

  assign beat_bytes = beat_len(ptr_reg, left_reg);
  assign last_beat  = ({5'h00, beat_bytes} == left_reg);

  // The instruction side is stalled while an access is open.
  // single access open
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      req_ready_out <= 1'b0;
    else
      req_ready_out <= (state_reg == dsio_pkg::DSIO_IDLE) && !req_valid_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg     <= dsio_pkg::DSIO_IDLE;
      req_reg       <= '0;
      left_reg      <= `DSIO_ZERO8;
      ptr_reg       <= `DSIO_ZERO32;
      load_sent_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        dsio_pkg::DSIO_IDLE:
          if (req_valid_in && req_ready_out)
          begin
            req_reg       <= req_in;
            left_reg      <= (req_in.byte_count > `DSIO_MAX_BYTES) ? `DSIO_MAX_BYTES : req_in.byte_count;
            ptr_reg       <= req_in.ea;
            load_sent_reg <= !req_in.is_load;
            state_reg     <= dsio_pkg::DSIO_REQ0;
          end
        dsio_pkg::DSIO_REQ0:
          state_reg <= dsio_pkg::DSIO_REQ1;
        dsio_pkg::DSIO_REQ1:
          if (addr_acknowledge_s)
          begin
            load_sent_reg <= 1'b1;
            state_reg     <= load_sent_reg ? dsio_pkg::DSIO_DATA : dsio_pkg::DSIO_REQ0;
          end
        dsio_pkg::DSIO_DATA:
          if (ta_s)
          begin
            load_sent_reg <= 1'b1;
            ptr_reg       <= ptr_reg + {29'h0, beat_bytes};
            left_reg      <= left_reg - {5'h00, beat_bytes};
            state_reg     <= last_beat ? dsio_pkg::DSIO_WAIT : dsio_pkg::DSIO_REQ0;
          end
        dsio_pkg::DSIO_WAIT:
          if (tea_seen_reg)
            state_reg <= dsio_pkg::DSIO_RPLY;
          else if (strobe_s && (code_s == `DSIO_XC_LOAD_RPLY || code_s == `DSIO_XC_STORE_RPLY)
                   && addr_s[3:0] == processor_tag_in)
            state_reg <= dsio_pkg::DSIO_RPLY;
        dsio_pkg::DSIO_RPLY:
          state_reg <= dsio_pkg::DSIO_IDLE;
        default:
          state_reg <= dsio_pkg::DSIO_IDLE;
      endcase
    end
  end

  // Address and code pins: bit 0 of the bus is the MSB of the vector.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      addr_out                  <= `DSIO_ZERO32;
      ext_transfer_code_out     <= `DSIO_ZERO8;
      ext_addr_start_strobe_out <= 1'b0;
      addr_oe_n_out             <= 1'b1;
    end
    else
    begin
      ext_addr_start_strobe_out <= 1'b0;
      addr_oe_n_out             <= 1'b1;
      if (state_reg == dsio_pkg::DSIO_REQ0)
      begin
        addr_out <= {`DSIO_ZERO2, req_reg.user_mode ? req_reg.seg[30] : req_reg.seg[29],
                     req_reg.seg[28:4], processor_tag_in};
        if (!load_sent_reg)
          ext_transfer_code_out <= `DSIO_XC_LOAD_REQ;
        else if (req_reg.is_load)
          ext_transfer_code_out <= last_beat ? `DSIO_XC_LOAD_LAST : `DSIO_XC_LOAD_IMM;
        else
          ext_transfer_code_out <= last_beat ? `DSIO_XC_STORE_LAST : `DSIO_XC_STORE_IMM;
        ext_addr_start_strobe_out <= 1'b1;
        addr_oe_n_out             <= 1'b0;
      end
      else if (state_reg == dsio_pkg::DSIO_REQ1)
      begin
        addr_out <= {req_reg.seg[3:0], ptr_reg[27:0]};
        ext_transfer_code_out <= load_sent_reg ? {5'h00, beat_bytes} : left_reg;
        addr_oe_n_out         <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      upper_data_lanes_out <= `DSIO_ZERO32;
      data_oe_n_out        <= 1'b1;
      load_data_out        <= `DSIO_ZERO32;
      load_data_valid_out  <= 1'b0;
    end
    else
    begin
      upper_data_lanes_out <= store_data_in;
      data_oe_n_out        <= !(state_reg == dsio_pkg::DSIO_DATA && !req_reg.is_load);
      load_data_valid_out  <= (state_reg == dsio_pkg::DSIO_DATA) && req_reg.is_load && ta_s;
      if ((state_reg == dsio_pkg::DSIO_DATA) && req_reg.is_load && ta_s)
        load_data_out <= dh_s;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      tea_seen_reg <= 1'b0;
    else if (state_reg == dsio_pkg::DSIO_IDLE)
      tea_seen_reg <= 1'b0;
    else if (tea_s && state_reg != dsio_pkg::DSIO_WAIT)
      tea_seen_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      done_out <= '0;
    else
    begin
      done_out.done   <= (state_reg == dsio_pkg::DSIO_RPLY) && !tea_seen_reg;
      done_out.mcheck <= (state_reg == dsio_pkg::DSIO_RPLY) && tea_seen_reg;
      done_out.error  <= (state_reg == dsio_pkg::DSIO_WAIT) && !tea_seen_reg && strobe_s
                         && (code_s == `DSIO_XC_LOAD_RPLY || code_s == `DSIO_XC_STORE_RPLY)
                         && addr_s[3:0] == processor_tag_in && addr_s[29];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      parity_error_out <= 1'b0;
    else
      parity_error_out <= parity_enable_in && strobe_s && !par_ok(addr_s, par_s);
  end

  chk_strobe_one_cycle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ext_addr_start_strobe_out |=> !ext_addr_start_strobe_out)
    else $error("start strobe held two cycles");
  chk_first_beat_reserved: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ext_addr_start_strobe_out |-> addr_out[31:30] == 2'h0)
    else $error("reserved lines driven high");
  chk_first_beat_tag: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ext_addr_start_strobe_out |-> addr_out[3:0] == $past(processor_tag_in))
    else $error("sender tag wrong");
  chk_beat_count_range: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ($past(state_reg) == dsio_pkg::DSIO_REQ1 && $past(load_sent_reg)) |->
      ext_transfer_code_out >= 8'h01 && ext_transfer_code_out <= 8'h04)
    else $error("beat count out of range");
  chk_total_count_cap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ($past(state_reg) == dsio_pkg::DSIO_REQ1) |-> ext_transfer_code_out <= `DSIO_MAX_BYTES)
    else $error("total count above maximum");
  chk_no_accept_busy: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_reg != dsio_pkg::DSIO_IDLE |=> !req_ready_out)
    else $error("ready while access open");
  chk_mcheck_cause: assert property (@(posedge clk_in) disable iff (!resetn_in)
    done_out.mcheck |-> $past(tea_seen_reg))
    else $error("machine check without transfer error");
  chk_done_after_wait: assert property (@(posedge clk_in) disable iff (!resetn_in)
    done_out.done |-> $past(state_reg, 2) == dsio_pkg::DSIO_WAIT)
    else $error("completion without awaited reply");
endmodule
`default_nettype wire

// >>> dsio_bucm.sv
// Behavioural I/O unit controller that answers direct-store operations on the bus.
`timescale 1ns/1ps
`default_nettype none
`include "dsio_regs.svh"
module dsio_bucm (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [31:0] dev_addr_in,
  input  wire logic [7:0]  dev_code_in,
  input  wire logic        dev_stb_in,
  input  wire logic        dev_oe_n_in,
  input  wire logic        err_in,
  input  wire logic        tea_in,
  input  wire logic        bad_tag_in,
  input  wire logic        bad_par_in,
  input  wire logic        kick_in,
  output var  logic [31:0] addr_out,
  output var  logic [7:0]  code_out,
  output var  logic        stb_out,
  output var  logic [3:0]  par_out,
  output var  logic        addr_acknowledge_out,
  output var  logic        tea_out,
  output var  logic        dack_out,
  output var  logic [31:0] lanes_out
);
  logic [3:0]  stag_reg;
  logic [8:0]  utag_reg;
  logic [7:0]  op_reg;
  logic [3:0]  dcnt_reg;
  logic [3:0]  rcnt_reg;
  logic [31:0] last_a_reg;
  logic [31:0] last_d_reg;
  logic [7:0]  last_c_reg;
  logic        rply;
  logic        rply2;
  assign rply = rcnt_reg == 4'hc;
  assign rply2 = rcnt_reg == 4'hd;
  // Released lines show the inverse of their last level, except zero in the cycle after a reply beat.
  // reply beats
  assign addr_out = !dev_oe_n_in ? dev_addr_in :
    rply ? {2'h0, err_in, utag_reg, 16'h0000, stag_reg ^ {4{bad_tag_in}}} : rply2 ? 32'h0000_0000 : ~last_a_reg;
  assign code_out = !dev_oe_n_in ? dev_code_in :
    rply ? (op_reg == `DSIO_XC_LOAD_LAST ? `DSIO_XC_LOAD_RPLY : `DSIO_XC_STORE_RPLY) : rply2 ? 8'h00 : ~last_c_reg;
  assign stb_out = dev_stb_in | rply;
  assign addr_acknowledge_out = dcnt_reg == 4'h1 || rcnt_reg == 4'he;
  assign dack_out = dcnt_reg == 4'h6 && op_reg != `DSIO_XC_LOAD_REQ;
  assign tea_out = dack_out & tea_in;
  assign lanes_out = dack_out ? {24'h5a3cc3, op_reg} : ~last_d_reg;
  assign par_out = {~^addr_out[31:24], ~^addr_out[23:16], ~^addr_out[15:8], ~^addr_out[7:0]} ^ {4{bad_par_in}};
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      stag_reg <= 4'h0;
      utag_reg <= 9'h000;
      op_reg <= 8'h00;
      dcnt_reg <= 4'h0;
      rcnt_reg <= 4'h0;
      last_a_reg <= 32'h0000_0000;
      last_d_reg <= 32'h0000_0000;
      last_c_reg <= 8'h00;
    end
    else
    begin
      last_a_reg <= addr_out;
      last_d_reg <= lanes_out;
      last_c_reg <= code_out;
      if (dev_stb_in)
      begin
        stag_reg <= dev_addr_in[3:0];
        utag_reg <= dev_addr_in[28:20];
        op_reg <= dev_code_in;
      end
      dcnt_reg <= dev_stb_in ? 4'h1 : (dcnt_reg == 4'h0 || dcnt_reg == 4'h7) ? 4'h0 : dcnt_reg + 4'h1;
      if (kick_in || dev_stb_in && (dev_code_in == `DSIO_XC_LOAD_LAST || dev_code_in == `DSIO_XC_STORE_LAST))
        rcnt_reg <= 4'h1;
      else
        rcnt_reg <= (rcnt_reg == 4'h0 || rcnt_reg == 4'hf) ? 4'h0 : rcnt_reg + 4'h1;
    end
endmodule
`default_nettype wire

// >>> dsio_core_test.sv
// Self-checking testbench for the direct-store transaction block.
`timescale 1ns/1ps
`default_nettype none
`include "dsio_regs.svh"
module dsio_core_test;
  localparam logic [31:0] SEG = 32'h4a5b_6c7d;
  localparam logic [3:0]  TAG = 4'h9;
  logic                 clk_in = 1'b0;
  logic                 resetn_in = 1'b0;
  dsio_pkg::dsio_req_t  req = '0;
  logic                 req_v = 1'b0;
  logic                 par_en = 1'b0;
  logic                 err = 1'b0;
  logic                 transfer_error_ack = 1'b0;
  logic                 badt = 1'b0;
  logic                 badp = 1'b0;
  logic                 kick = 1'b0;
  logic [31:0]          a_bus, d_bus, a_o, d_o, ld_o, lanes;
  logic [7:0]           c_bus, c_o;
  logic [3:0]           par;
  logic                 stb_b, stb_o, addr_acknowledge, teab, dack, a_oe_n, d_oe_n, rdy, ldv, pe;
  dsio_pkg::dsio_done_t dn_o;
  logic [31:0]          pa[$];
  logic [31:0]          ld_q[$];
  logic [7:0]           pc[$];
  logic                 nxt = 1'b0;
  logic                 dn, er, mc, pe_s;
  int                   num_errors = 0;
  int                   samples_checked = 0;
  bit                   got;
  always #5 clk_in = ~clk_in;
  dsio_core dsio_core_i (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req), .req_valid_in(req_v),
    .store_data_in(32'hcafe_f00d), .processor_tag_in(TAG), .parity_enable_in(par_en), .addr_acknowledge_in(addr_acknowledge),
    .transfer_error_ack_in(teab), .data_ack_in(dack), .addr_in(a_bus), .ext_transfer_code_in(c_bus),
    .ext_addr_start_strobe_in(stb_b), .addr_parity_in(par), .upper_data_lanes_in(d_bus), .req_ready_out(rdy),
    .addr_out(a_o), .ext_transfer_code_out(c_o), .ext_addr_start_strobe_out(stb_o), .addr_oe_n_out(a_oe_n),
    .upper_data_lanes_out(d_o), .data_oe_n_out(d_oe_n), .load_data_out(ld_o), .load_data_valid_out(ldv),
    .done_out(dn_o), .parity_error_out(pe));
  dsio_bucm dsio_bucm_i (.clk_in(clk_in), .resetn_in(resetn_in), .dev_addr_in(a_o), .dev_code_in(c_o),
    .dev_stb_in(stb_o), .dev_oe_n_in(a_oe_n), .err_in(err), .tea_in(transfer_error_ack), .bad_tag_in(badt), .bad_par_in(badp),
    .kick_in(kick), .addr_out(a_bus), .code_out(c_bus), .stb_out(stb_b), .par_out(par), .addr_acknowledge_out(addr_acknowledge),
    .tea_out(teab), .dack_out(dack), .lanes_out(d_bus));
  always @(posedge clk_in)
  begin
    nxt <= stb_o;
    if (stb_o || nxt)
    begin
      pa.push_back(a_o);
      pc.push_back(c_o);
    end
    if (!d_oe_n) lanes <= d_o;
    if (ldv) ld_q.push_back(ld_o);
    if (dn_o.done || dn_o.mcheck) dn <= 1'b1;
    if (dn_o.error) er <= 1'b1;
    if (dn_o.mcheck) mc <= 1'b1;
    if (pe) pe_s <= 1'b1;
  end
  function automatic logic [31:0] p0(input logic um);
    return {2'h0, um ? SEG[30] : SEG[29], SEG[28:4], TAG};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_dn(input int lim, input bit want);
    int k;
    k = 0;
    while (!dn && k < lim)
    begin
      @(posedge clk_in);
      k++;
    end
    got = dn;
    if (want && !got)
    begin
      check("timeout", 32'h0, 32'h1);
      give_verdict();
    end
  endtask
  task automatic go(input logic ld, input logic um, input logic [31:0] ea, input logic [7:0] n, input bit want);
    int k;
    pa.delete();
    pc.delete();
    ld_q.delete();
    dn = 1'b0;
    er = 1'b0;
    mc = 1'b0;
    pe_s = 1'b0;
    k = 0;
    while (!rdy && k < 400)
    begin
      @(posedge clk_in);
      k++;
    end
    if (!rdy)
    begin
      check("ready", 32'h0, 32'h1);
      give_verdict();
    end
    req <= '{ld, um, ea, n, SEG};
    req_v <= 1'b1;
    @(posedge clk_in);
    req_v <= 1'b0;
    wait_dn(400, want);
  endtask
  task automatic t_store();
    go(1'b0, 1'b1, 32'h0000_1230, 8'h04, 1'b1);
    check("ops", 32'(pc.size()), 32'h2);
    check("pkt0", pa[0], p0(1'b1));
    check("code", pc[0], `DSIO_XC_STORE_LAST);
    check("count", pc[1], 32'h4);
    check("pkt1", pa[1], {SEG[3:0], 28'h000_1230});
    check("lanes", lanes, 32'hcafe_f00d);
    check("error", er, 32'h0);
  endtask
  task automatic t_load();
    go(1'b1, 1'b0, 32'h0000_2240, 8'h08, 1'b1);
    check("ops", 32'(pc.size()), 32'h6);
    check("pkt0", pa[0], p0(1'b0));
    check("req", pc[0], `DSIO_XC_LOAD_REQ);
    check("total", pc[1], 32'h8);
    check("imm", pc[2], `DSIO_XC_LOAD_IMM);
    check("last", pc[4], `DSIO_XC_LOAD_LAST);
    check("count", pc[5], 32'h4);
    check("data0", ld_q[0], {24'h5a3cc3, `DSIO_XC_LOAD_IMM});
    check("data1", ld_q[1], {24'h5a3cc3, `DSIO_XC_LOAD_LAST});
  endtask
  task automatic t_cross_err();
    err <= 1'b1;
    go(1'b0, 1'b1, 32'h0000_1236, 8'h04, 1'b1);
    check("imm", pc[0], `DSIO_XC_STORE_IMM);
    check("count", pc[1], 32'h2);
    check("last", pc[2], `DSIO_XC_STORE_LAST);
    check("error", er, 32'h1);
    err <= 1'b0;
  endtask
  task automatic t_dword();
    go(1'b0, 1'b1, 32'h0000_1232, 8'h04, 1'b1);
    check("ops", 32'(pc.size()), 32'h2);
    check("code", pc[0], `DSIO_XC_STORE_LAST);
    check("count", pc[1], 32'h4);
  endtask
  task automatic t_tag();
    badt <= 1'b1;
    go(1'b0, 1'b1, 32'h0000_1230, 8'h04, 1'b0);
    check("foreign", 32'(got), 32'h0);
    badt <= 1'b0;
    kick <= 1'b1;
    @(posedge clk_in);
    kick <= 1'b0;
    wait_dn(60, 1'b1);
    dn = 1'b0;
    kick <= 1'b1;
    @(posedge clk_in);
    kick <= 1'b0;
    wait_dn(60, 1'b0);
    check("stray", 32'(got), 32'h0);
  endtask
  task automatic t_tea();
    transfer_error_ack <= 1'b1;
    go(1'b0, 1'b1, 32'h0000_1230, 8'h04, 1'b1);
    check("mcheck", mc, 32'h1);
    transfer_error_ack <= 1'b0;
  endtask
  task automatic t_parity();
    par_en <= 1'b1;
    go(1'b0, 1'b1, 32'h0000_1230, 8'h04, 1'b1);
    check("parity", pe_s, 32'h0);
    badp <= 1'b1;
    go(1'b0, 1'b1, 32'h0000_1230, 8'h04, 1'b0);
    check("parity", pe_s, 32'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_store();
    t_load();
    t_cross_err();
    t_dword();
    t_tag();
    t_tea();
    t_parity();
    give_verdict();
  end
endmodule
`default_nettype wire
